//--- design/asf_pkg.sv
`default_nettype none
package asf_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int ASF_DEPTH = 32;
    localparam int ASF_AW = 5;
    localparam int ASF_CW = 6;
    localparam int ASF_RAW_W = 10;
    localparam int ASF_OUT_W = 16;
    localparam int ASF_PAD_W = ASF_OUT_W - ASF_RAW_W;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ASF_ADDR_X_LOW = 8'h32;
    localparam logic [7:0] ASF_ADDR_X_HIGH = 8'h33;
    localparam logic [7:0] ASF_ADDR_Y_LOW = 8'h34;
    localparam logic [7:0] ASF_ADDR_Y_HIGH = 8'h35;
    localparam logic [7:0] ASF_ADDR_Z_LOW = 8'h36;
    localparam logic [7:0] ASF_ADDR_Z_HIGH = 8'h37;
    localparam logic [7:0] ASF_ADDR_CTL = 8'h38;
    localparam logic [7:0] ASF_ADDR_STATUS = 8'h39;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int ASF_MODE_MSB = 7;
    localparam int ASF_MODE_LSB = 6;
    localparam int ASF_TRIG_SEL_BIT = 5;
    localparam int ASF_SAMPLES_MSB = 4;
    localparam int ASF_TRIG_FLAG_BIT = 7;
    localparam logic [7:0] ASF_CTL_RESET = 8'h00;
    localparam logic [7:0] ASF_RDATA_RESET = 8'h00;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ASF_BYPASS = 2'b00,
        ASF_COLLECT = 2'b01,
        ASF_STREAM = 2'b10,
        ASF_TRIGGER = 2'b11
    } asf_mode_type;

    typedef enum logic [1:0] {
        ASF_CMD_READ = 2'b00,
        ASF_CMD_WRITE = 2'b01,
        ASF_CMD_FINISH = 2'b10
    } asf_cmd_kind_type;

    typedef enum logic [1:0] {
        ASF_LINK_IDLE = 2'b01,
        ASF_LINK_WAIT = 2'b10
    } asf_link_state_type;

    typedef struct packed {
        logic [ASF_RAW_W-1:0] x;
        logic [ASF_RAW_W-1:0] y;
        logic [ASF_RAW_W-1:0] z;
    } asf_sample_type;

    typedef struct packed {
        asf_cmd_kind_type kind;
        logic [7:0] addr;
        logic [7:0] wdata;
    } asf_cmd_type;

endpackage : asf_pkg
`default_nettype wire

//--- design/asf_sample_mem.sv
`timescale 1ns/100ps
`default_nettype none
module asf_sample_mem
    import asf_pkg::*;
(
    input wire logic clock,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic [ASF_AW-1:0] wr_addr,
    input wire asf_sample_type wr_data,
    input wire logic [ASF_AW-1:0] rd_addr,
    output asf_sample_type rd_data_q
);

    asf_sample_type mem_q [ASF_DEPTH];

    // no reset: contents are only read after being written
    always_ff @(posedge clock) begin
        if (ce) begin
            if (wr_en) begin
                mem_q[wr_addr] <= wr_data;
            end
            rd_data_q <= mem_q[rd_addr];
        end
    end

endmodule : asf_sample_mem
`default_nettype wire

//--- design/asf_sample_fifo.sv
// What this block does
// R1 - six read-only axis data bytes 0x32-0x37
// R2 - two's complement, low byte at lower address
// R3 - host reads all six bytes in one burst
// R4 - control bits 7:6 select buffer mode
// R5 - collect mode stops when full, resumes later
// R6 - stream mode overwrites oldest when full
// R7 - trigger mode keeps pre-trigger, then fills
// R8 - trigger select bit picks interrupt pin event
// R9 - sample count zero sets watermark at once
// R10 - count is watermark level in collect/stream
// R11 - trigger mode count is retained pre-trigger samples
// R12 - host avoids zero count in trigger mode
// R13 - status bit 7 trigger seen, bit 6 zero
// R14 - status bits 5:0 give stored entries
// R15 - each data read access pops one entry
// R16 - 32 stored plus one output stage sample
// R17 - ready, watermark, overrun cleared by data reads
// R18 - justify selects left or sign-extended right
// R19 - sleep blocks storing and hides data ready
// R20 - dropped sample, or bypass overwrite of an unread sample, sets overrun
// R21 - watermark follows entries at or above count
`timescale 1ns/100ps
`default_nettype none
module asf_sample_fifo
    import asf_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic link_clock,
    input wire logic cmd_valid,
    input wire asf_cmd_type cmd,
    output logic cmd_ready_q,
    output logic rsp_valid_q,
    output logic [7:0] rsp_rdata_q,
    input wire logic sample_valid,
    input wire asf_sample_type sample,
    input wire logic first_interrupt_pin_event,
    input wire logic second_interrupt_pin_event,
    input wire logic sleep_mode,
    input wire logic justify_left,
    output logic data_ready_q,
    output logic watermark_q,
    output logic overrun_q
);

    // ------------------------------------------------------------
    // link side: one command in flight, toggle handshake
    // ------------------------------------------------------------
    asf_link_state_type link_state_q;
    asf_cmd_type held_cmd_q;
    logic req_tgl_q;
    logic ack_s1_q;
    logic ack_s2_q;
    logic ack_s3_q;
    logic ack_tgl_q;
    logic [7:0] rdata_q;

    always_ff @(posedge link_clock or negedge arst_n) begin
        if (!arst_n) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            ack_s3_q <= 1'b0;
        end else begin
            ack_s1_q <= ack_tgl_q;
            ack_s2_q <= ack_s1_q;
            ack_s3_q <= ack_s2_q;
        end
    end

    // the held command stays put until the core answers, so the core
    // may sample it as a word once the toggle has been synchronised
    always_ff @(posedge link_clock or negedge arst_n) begin
        if (!arst_n) begin
            link_state_q <= ASF_LINK_IDLE;
            held_cmd_q <= '0;
            req_tgl_q <= 1'b0;
            cmd_ready_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_rdata_q <= ASF_RDATA_RESET;
        end else begin
            rsp_valid_q <= 1'b0;
            case (link_state_q)
                ASF_LINK_IDLE: begin
                    cmd_ready_q <= 1'b1;
                    if (cmd_valid && cmd_ready_q) begin
                        held_cmd_q <= cmd;
                        req_tgl_q <= ~req_tgl_q;
                        cmd_ready_q <= 1'b0;
                        link_state_q <= ASF_LINK_WAIT;
                    end
                end
                ASF_LINK_WAIT: begin
                    if (ack_s2_q != ack_s3_q) begin
                        rsp_valid_q <= 1'b1;
                        rsp_rdata_q <= rdata_q;
                        cmd_ready_q <= 1'b1;
                        link_state_q <= ASF_LINK_IDLE;
                    end
                end
                default: begin
                    link_state_q <= ASF_LINK_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // core side: command arrival
    // ------------------------------------------------------------
    logic req_s1_q;
    logic req_s2_q;
    logic cmd_hit;
    logic is_data_addr;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
        end else if (ce) begin
            req_s1_q <= req_tgl_q;
            req_s2_q <= req_s1_q;
        end
    end

    assign cmd_hit = req_s2_q != ack_tgl_q;
    assign is_data_addr = (held_cmd_q.addr >= ASF_ADDR_X_LOW) &&
                          (held_cmd_q.addr <= ASF_ADDR_Z_HIGH);

    // ------------------------------------------------------------
    // control register and decoded fields
    // ------------------------------------------------------------
    logic [7:0] ctl_q;
    asf_mode_type mode;
    logic [ASF_AW-1:0] samples;
    logic ctl_write;
    logic mode_change;

    assign mode = asf_mode_type'(ctl_q[ASF_MODE_MSB:ASF_MODE_LSB]); // R4
    assign samples = ctl_q[ASF_SAMPLES_MSB:0];
    assign ctl_write = cmd_hit && (held_cmd_q.kind == ASF_CMD_WRITE) &&
                       (held_cmd_q.addr == ASF_ADDR_CTL);
    assign mode_change = ctl_write &&
        (held_cmd_q.wdata[ASF_MODE_MSB:ASF_MODE_LSB] !=
         ctl_q[ASF_MODE_MSB:ASF_MODE_LSB]);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ctl_q <= ASF_CTL_RESET;
        end else if (ce && ctl_write) begin
            ctl_q <= held_cmd_q.wdata;
        end
    end

    // ------------------------------------------------------------
    // trigger capture
    // ------------------------------------------------------------
    logic trig_q;
    logic trig_src;

    assign trig_src = ctl_q[ASF_TRIG_SEL_BIT] ? second_interrupt_pin_event
                                              : first_interrupt_pin_event; // R8

    // rewriting the control register re-arms the trigger; an event in
    // the same cycle as the rewrite still counts
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            trig_q <= 1'b0;
        end else if (ce) begin
            if (mode == ASF_TRIGGER && trig_src) begin
                trig_q <= 1'b1; // R13
            end else if (ctl_write) begin
                trig_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // buffer datapath
    // ------------------------------------------------------------
    logic [ASF_AW-1:0] wr_ptr_q;
    logic [ASF_AW-1:0] rd_ptr_q;
    logic [ASF_CW-1:0] count_q;
    logic stale_q;
    logic out_valid_q;
    asf_sample_type out_q;
    asf_sample_type head_data;
    logic [ASF_CW-1:0] entries;
    logic accept;
    logic pop;
    logic full;
    logic direct;
    logic fifo_in;
    logic drop_old;
    logic drop_new;
    logic push;
    logic refill;
    logic head_adv;
    logic touched_q;

    assign accept = sample_valid && !sleep_mode; // R19
    assign pop = cmd_hit && (held_cmd_q.kind == ASF_CMD_FINISH) &&
                 touched_q; // R15
    assign full = count_q == ASF_CW'(ASF_DEPTH);
    assign direct = accept && !out_valid_q && (count_q == '0) &&
                    (mode != ASF_BYPASS);
    assign fifo_in = accept && !direct && (mode != ASF_BYPASS);
    assign drop_old = (mode == ASF_STREAM && full) || // R6
        (mode == ASF_TRIGGER && !trig_q && (count_q != '0) &&
         (count_q >= ASF_CW'(samples))); // R11
    assign drop_new = full && ((mode == ASF_COLLECT) || // R5
        (mode == ASF_TRIGGER && trig_q)); // R7
    assign push = fifo_in && !drop_new;
    // the memory answers one cycle after any pointer move or write
    assign refill = !out_valid_q && (count_q != '0) && !stale_q &&
                    !fifo_in && (mode != ASF_BYPASS);
    assign head_adv = (push && drop_old) || refill;
    assign entries = count_q + ASF_CW'(out_valid_q); // R16

    asf_sample_mem u_mem (
        .clock(clock),
        .ce(ce),
        .wr_en(ce && push),
        .wr_addr(wr_ptr_q),
        .wr_data(sample),
        .rd_addr(rd_ptr_q),
        .rd_data_q(head_data)
    );

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            stale_q <= 1'b1;
        end else if (ce) begin
            stale_q <= push || head_adv || mode_change;
            if (mode_change) begin
                wr_ptr_q <= '0;
                rd_ptr_q <= '0;
                count_q <= '0;
            end else begin
                if (push) begin
                    wr_ptr_q <= wr_ptr_q + 1'b1;
                end
                if (head_adv) begin
                    rd_ptr_q <= rd_ptr_q + 1'b1;
                end
                if (push && !head_adv) begin
                    count_q <= count_q + 1'b1;
                end else if (!push && head_adv) begin
                    count_q <= count_q - 1'b1;
                end
            end
        end
    end

    // output stage: the extra sample beyond the stored ones
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            out_valid_q <= 1'b0;
            out_q <= '0;
        end else if (ce) begin
            if (mode == ASF_BYPASS && accept) begin
                out_q <= sample;
                out_valid_q <= 1'b1;
            end else if (direct) begin
                out_q <= sample;
                out_valid_q <= 1'b1;
            end else if (refill) begin
                out_q <= head_data;
                out_valid_q <= 1'b1;
            end else if (pop) begin
                out_valid_q <= 1'b0; // R15
            end
        end
    end

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    logic lost;
    logic wm_level;

    assign lost = (mode == ASF_BYPASS) ? (accept && out_valid_q && !pop)
                                       : (fifo_in && drop_new); // R20
    assign wm_level = (samples == '0) || // R9
        (((mode == ASF_COLLECT) || (mode == ASF_STREAM)) &&
         (entries >= ASF_CW'(samples))); // R10

    // overrun: a loss in the same cycle as a data read still shows
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            overrun_q <= 1'b0;
            watermark_q <= 1'b0;
            data_ready_q <= 1'b0;
        end else if (ce) begin
            if (lost) begin
                overrun_q <= 1'b1; // R20
            end else if (pop) begin
                overrun_q <= 1'b0; // R17
            end
            watermark_q <= wm_level; // R21
            data_ready_q <= out_valid_q && !sleep_mode; // R17 R19
        end
    end

    // ------------------------------------------------------------
    // register reads and answers
    // ------------------------------------------------------------
    logic [ASF_OUT_W-1:0] fx;
    logic [ASF_OUT_W-1:0] fy;
    logic [ASF_OUT_W-1:0] fz;
    logic [7:0] rd_value;

    function automatic logic [ASF_OUT_W-1:0] fmt(
        input logic [ASF_RAW_W-1:0] raw,
        input logic left
    );
        if (left) begin
            fmt = {raw, {ASF_PAD_W{1'b0}}}; // R18
        end else begin
            fmt = {{ASF_PAD_W{raw[ASF_RAW_W-1]}}, raw}; // R18
        end
    endfunction : fmt

    assign fx = fmt(out_q.x, justify_left);
    assign fy = fmt(out_q.y, justify_left);
    assign fz = fmt(out_q.z, justify_left);

    always_comb begin
        rd_value = ASF_RDATA_RESET;
        if (held_cmd_q.addr == ASF_ADDR_X_LOW) begin
            rd_value = fx[7:0]; // R1 R2
        end else if (held_cmd_q.addr == ASF_ADDR_X_HIGH) begin
            rd_value = fx[15:8]; // R2
        end else if (held_cmd_q.addr == ASF_ADDR_Y_LOW) begin
            rd_value = fy[7:0]; // R1
        end else if (held_cmd_q.addr == ASF_ADDR_Y_HIGH) begin
            rd_value = fy[15:8];
        end else if (held_cmd_q.addr == ASF_ADDR_Z_LOW) begin
            rd_value = fz[7:0]; // R1
        end else if (held_cmd_q.addr == ASF_ADDR_Z_HIGH) begin
            rd_value = fz[15:8];
        end else if (held_cmd_q.addr == ASF_ADDR_CTL) begin
            rd_value = ctl_q;
        end else if (held_cmd_q.addr == ASF_ADDR_STATUS) begin
            rd_value = {trig_q, 1'b0, entries}; // R13 R14
        end
    end

    // outside bypass mode the output stage only moves on a finish, so every
    // byte of one burst comes from the same sample
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ack_tgl_q <= 1'b0;
            rdata_q <= ASF_RDATA_RESET;
            touched_q <= 1'b0;
        end else if (ce && cmd_hit) begin
            ack_tgl_q <= req_s2_q;
            if (held_cmd_q.kind == ASF_CMD_READ) begin
                rdata_q <= rd_value;
                if (is_data_addr) begin
                    touched_q <= 1'b1;
                end
            end else if (held_cmd_q.kind == ASF_CMD_FINISH) begin
                touched_q <= 1'b0;
            end
        end
    end

endmodule : asf_sample_fifo
`default_nettype wire

//--- dv/asf_sample_fifo_chk.sv
`timescale 1ns/100ps
`default_nettype none
module asf_sample_fifo_chk
    import asf_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic link_clock,
    input wire logic cmd_valid,
    input wire asf_cmd_type cmd,
    input wire logic cmd_ready_q,
    input wire logic rsp_valid_q,
    input wire logic [7:0] rsp_rdata_q,
    input wire logic sample_valid,
    input wire asf_sample_type sample,
    input wire logic first_interrupt_pin_event,
    input wire logic second_interrupt_pin_event,
    input wire logic sleep_mode,
    input wire logic justify_left,
    input wire logic data_ready_q,
    input wire logic watermark_q,
    input wire logic overrun_q
);
    // ------------------------------------------------
    // last command taken, and a shadow of the control byte
    // ------------------------------------------------
    logic read_q;
    logic [7:0] addr_q;
    logic [7:0] ctl_q;
    logic rd_rsp;
    logic ctl_wr;
    assign rd_rsp = rsp_valid_q && read_q;
    assign ctl_wr = cmd_valid && cmd_ready_q && cmd.kind == ASF_CMD_WRITE
        && cmd.addr == ASF_ADDR_CTL;
    always_ff @(posedge link_clock or negedge arst_n) begin
        if (!arst_n) begin
            read_q <= 1'b0;
            addr_q <= 8'h00;
        end else if (cmd_valid && cmd_ready_q) begin
            read_q <= cmd.kind == ASF_CMD_READ;
            addr_q <= cmd.addr;
        end
    end
    always_ff @(posedge link_clock or negedge arst_n) begin
        if (!arst_n) begin
            ctl_q <= ASF_CTL_RESET;
        end else if (ctl_wr) begin
            ctl_q <= cmd.wdata;
        end
    end
    sequence s_take;
        cmd_valid && cmd_ready_q;
    endsequence
    sequence s_answer;
        !cmd_ready_q ##[1:30] (rsp_valid_q && cmd_ready_q);
    endsequence
    // ------------------------------------------------
    // assertions
    // ------------------------------------------------
    a_take_answered:
    assert property (@(posedge link_clock) disable iff (!arst_n)
        s_take |=> s_answer) else $error("command not answered");
    a_unmapped_zero:
    assert property (@(posedge link_clock) disable iff (!arst_n)
        rd_rsp && (addr_q < 8'h32 || addr_q > 8'h39) |-> rsp_rdata_q == 8'h00)
        else $error("unmapped read not zero");
    a_status_shape:
    assert property (@(posedge link_clock) disable iff (!arst_n)
        rd_rsp && addr_q == ASF_ADDR_STATUS
        |-> !rsp_rdata_q[6] && rsp_rdata_q[5:0] <= 6'h21)
        else $error("status byte malformed");
    a_ctl_readback:
    assert property (@(posedge link_clock) disable iff (!arst_n)
        rd_rsp && addr_q == ASF_ADDR_CTL |-> rsp_rdata_q == ctl_q)
        else $error("control readback wrong");
    a_zero_count_wm:
    assert property (@(posedge link_clock) disable iff (!arst_n)
        ctl_wr && cmd.wdata[4:0] == 5'h00 |-> ##[1:12] watermark_q)
        else $error("zero count left watermark low");
    a_sleep_hides:
    assert property (@(posedge clock) disable iff (!arst_n)
        ce && sleep_mode |=> !data_ready_q) else $error("ready during sleep");
    a_ready_awake:
    assert property (@(posedge clock) disable iff (!arst_n)
        $rose(data_ready_q) |-> !$past(sleep_mode))
        else $error("ready rose in sleep");
    a_sample_ready:
    assert property (@(posedge clock) disable iff (!arst_n)
        ce && sample_valid && !sleep_mode
        |-> ##[1:3] (data_ready_q || sleep_mode)) else $error("no ready");
    a_overrun_cause:
    assert property (@(posedge clock) disable iff (!arst_n)
        $rose(overrun_q) |-> $past(sample_valid) || $past(sample_valid, 2)
        || $past(sample_valid, 3)) else $error("overrun without sample");
endmodule : asf_sample_fifo_chk
bind asf_sample_fifo asf_sample_fifo_chk u_asf_sample_fifo_chk (.clock,
    .arst_n, .ce, .link_clock, .cmd_valid, .cmd, .cmd_ready_q, .rsp_valid_q,
    .rsp_rdata_q, .sample_valid, .sample, .first_interrupt_pin_event,
    .second_interrupt_pin_event, .sleep_mode, .justify_left, .data_ready_q,
    .watermark_q, .overrun_q);
`default_nettype wire

//--- dv/asf_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module asf_host_model
    import asf_pkg::*;
(
    input wire logic cmd_ready_q,
    input wire logic rsp_valid_q,
    input wire logic [7:0] rsp_rdata_q,
    output logic link_clock,
    output logic cmd_valid,
    output asf_cmd_type cmd
);
    // ------------------------------------------------
    // link clock, parked low between host accesses
    // ------------------------------------------------
    logic run = 1'b1;
    initial begin
        link_clock = 1'b0;
        cmd_valid = 1'b0;
        cmd = '0;
        #3.7;
        forever begin
            #40;
            if (run || link_clock) link_clock = ~link_clock;
        end
    end
    // request held until taken; released fields show inverted junk
    task automatic xfer(input asf_cmd_kind_type k, input logic [7:0] a,
            input logic [7:0] d, output logic [7:0] q);
        int n;
        run = 1'b1;
        @(posedge link_clock);
        #1;
        cmd_valid = 1'b1;
        cmd = '{k, a, d};
        n = 0;
        do begin
            @(posedge link_clock);
            n++;
        end while (cmd_ready_q !== 1'b1 && n < 40);
        #1;
        cmd_valid = 1'b0;
        cmd = asf_cmd_type'(~cmd);
        do begin
            @(posedge link_clock);
            n++;
        end while (rsp_valid_q !== 1'b1 && n < 80);
        q = rsp_rdata_q;
    endtask : xfer
    task automatic close_access;
        logic [7:0] q;
        xfer(ASF_CMD_FINISH, 8'h00, 8'h00, q);
        repeat (2) @(posedge link_clock);
        run = 1'b0;
    endtask : close_access
    task automatic access(input asf_cmd_kind_type k, input logic [7:0] a,
            input logic [7:0] d, output logic [7:0] q);
        xfer(k, a, d, q);
        close_access();
    endtask : access
    // whole sample in one access, since the closing finish pops it
    task automatic burst(output logic [47:0] s);
        logic [7:0] q;
        for (int i = 0; i < 6; i++) begin
            xfer(ASF_CMD_READ, ASF_ADDR_X_LOW + 8'(i), 8'h00, q);
            s[8*i +: 8] = q;
        end
        close_access();
    endtask : burst
endmodule : asf_host_model
`default_nettype wire

//--- dv/asf_sample_fifo_bench.sv
`timescale 1ns/100ps
`default_nettype none
module asf_sample_fifo_bench
    import asf_pkg::*;
;
    logic clock = 1'b0;
    logic arst_n, ce, link_clock, cmd_valid, cmd_ready_q, rsp_valid_q;
    logic sample_valid, first_interrupt_pin_event;
    logic second_interrupt_pin_event, sleep_mode, justify_left;
    logic data_ready_q, watermark_q, overrun_q;
    logic [7:0] rsp_rdata_q, q;
    logic [47:0] s;
    asf_cmd_type cmd;
    asf_sample_type sample;
    int bad_count = 0;
    int checks = 0;
    asf_sample_fifo u_asf_sample_fifo (.clock, .arst_n, .ce, .link_clock,
        .cmd_valid, .cmd, .cmd_ready_q, .rsp_valid_q, .rsp_rdata_q,
        .sample_valid, .sample, .first_interrupt_pin_event,
        .second_interrupt_pin_event, .sleep_mode, .justify_left,
        .data_ready_q, .watermark_q, .overrun_q);
    asf_host_model u_asf_host_model (.cmd_ready_q, .rsp_valid_q,
        .rsp_rdata_q, .link_clock, .cmd_valid, .cmd);
    always #12.5 clock = ~clock;
    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    task automatic chk(input string n, input logic [47:0] seen,
            input logic [47:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic results;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results
    task automatic tick;
        @(posedge clock);
        #1;
    endtask : tick
    task automatic rd(input logic [7:0] a);
        u_asf_host_model.access(ASF_CMD_READ, a, 8'h00, q);
    endtask : rd
    task automatic wr(input logic [7:0] d);
        u_asf_host_model.access(ASF_CMD_WRITE, ASF_ADDR_CTL, d, q);
    endtask : wr
    task automatic push(input int i);
        tick();
        sample_valid = 1'b1;
        sample = '{10'(i), ~10'(i), 10'(3 * i)};
        tick();
        sample_valid = 1'b0;
        sample = asf_sample_type'(~sample);
        repeat (3) tick();
    endtask : push
    function automatic logic [15:0] ej(input logic [9:0] r);
        return justify_left ? {r, 6'h00} : {{6{r[9]}}, r};
    endfunction : ej
    task automatic pop(input int i);
        u_asf_host_model.burst(s);
        chk("sample", s, {ej(10'(3 * i)), ej(~10'(i)), ej(10'(i))});
    endtask : pop
    task automatic pulse(input logic sel);
        tick();
        first_interrupt_pin_event = !sel;
        second_interrupt_pin_event = sel;
        tick();
        first_interrupt_pin_event = 1'b0;
        second_interrupt_pin_event = 1'b0;
    endtask : pulse
    // ------------------------------------------------
    // tests
    // ------------------------------------------------
    initial begin
        arst_n = 1'b0;
        ce = 1'b1;
        sample_valid = 1'b0;
        sample = '0;
        first_interrupt_pin_event = 1'b0;
        second_interrupt_pin_event = 1'b0;
        sleep_mode = 1'b0;
        justify_left = 1'b0;
        repeat (5) @(posedge clock);
        #1;
        arst_n = 1'b1;
        repeat (8) tick();
        rd(ASF_ADDR_CTL);
        chk("ctl reset", q, ASF_CTL_RESET);
        rd(ASF_ADDR_STATUS);
        chk("status reset", q, 8'h00);
        rd(8'h50);
        chk("unmapped", q, 8'h00);
        chk("wm reset", watermark_q, 1'b1);
        $display("test reset done");
        push(1);
        chk("ready", data_ready_q, 1'b1);
        pop(1);
        chk("ready clear", data_ready_q, 1'b0);
        push(2);
        push(3);
        chk("overrun", overrun_q, 1'b1);
        pop(3);
        chk("overrun clear", overrun_q, 1'b0);
        tick();
        justify_left = 1'b1;
        push(4);
        pop(4);
        tick();
        justify_left = 1'b0;
        sleep_mode = 1'b1;
        push(5);
        chk("sleep ready", data_ready_q, 1'b0);
        rd(ASF_ADDR_STATUS);
        chk("sleep store", q, 8'h00);
        tick();
        sleep_mode = 1'b0;
        $display("test bypass done");
        wr(8'h44);
        rd(ASF_ADDR_CTL);
        chk("ctl rw", q, 8'h44);
        chk("wm low", watermark_q, 1'b0);
        for (int i = 0; i < 35; i++) push(10 + i);
        rd(ASF_ADDR_STATUS);
        chk("collect full", q, 8'h21);
        chk("drop overrun", overrun_q, 1'b1);
        pop(10);
        push(45);
        for (int i = 1; i < 33; i++) begin
            pop(10 + i);
            if (i == 29) chk("wm at level", watermark_q, 1'b1);
            if (i == 30) chk("wm below", watermark_q, 1'b0);
        end
        pop(45);
        rd(ASF_ADDR_STATUS);
        chk("drained", q, 8'h00);
        $display("test collect done");
        wr(8'h84);
        for (int i = 0; i < 35; i++) push(50 + i);
        rd(ASF_ADDR_STATUS);
        chk("stream full", q, 8'h21);
        pop(50);
        for (int i = 53; i < 85; i++) pop(i);
        $display("test stream done");
        wr(8'hE3);
        for (int i = 0; i < 6; i++) push(90 + i);
        pulse(1'b0);
        rd(ASF_ADDR_STATUS);
        chk("trig sel", q[7:6], 2'b00);
        pulse(1'b1);
        rd(ASF_ADDR_STATUS);
        chk("pre trigger", q, 8'h84);
        for (int i = 0; i < 32; i++) push(100 + i);
        rd(ASF_ADDR_STATUS);
        chk("trig full", q, 8'hA1);
        chk("trig overrun", overrun_q, 1'b1);
        wr(8'hC3);
        rd(ASF_ADDR_STATUS);
        chk("rearm", q[7:6], 2'b00);
        pulse(1'b0);
        rd(ASF_ADDR_STATUS);
        chk("trig first", q[7:6], 2'b10);
        for (int m = 0; m < 3; m++) begin
            wr({2'(m), 6'h00});
            chk("wm zero", watermark_q, 1'b1);
        end
        $display("test trigger done");
        results();
    end
    initial begin
        #2000000;
        bad_count++;
        results();
    end
endmodule : asf_sample_fifo_bench
`default_nettype wire
